// File: src/ctb_pkg.sv
// Package of constants and types plus the pin synchroniser for the timebase.
`timescale 1ns/100ps
package ctb_pkg;
    // ***********************************************************************
    // Register map and fields
    // ***********************************************************************
    localparam logic [2:0] CTB_IDX_CNT_LO = 3'h0;
    localparam logic [2:0] CTB_IDX_CNT_HI = 3'h1;
    localparam logic [2:0] CTB_IDX_MODE = 3'h2;
    localparam logic [2:0] CTB_IDX_STAT = 3'h3;
    localparam logic [2:0] CTB_IDX_MASK = 3'h4;
    localparam int CTB_MODE_IRQEN = 0;
    localparam int CTB_MODE_SEL_LO = 1;
    localparam int CTB_MODE_IDLE = 4;
    localparam int CTB_MODE_WDOG = 5;
    localparam logic [2:0] CTB_SEL_RESET = 3'h0;
    localparam logic CTB_WDOG_RESET = 1'b1;
    localparam logic CTB_MASK_RESET = 1'b1;
    localparam logic [1:0] CTB_RESP_OKAY = 2'h0;
    localparam logic [1:0] CTB_RESP_SLVERR = 2'h2;
    // ***********************************************************************
    // Tick sources and timing
    // ***********************************************************************
    localparam logic [2:0] CTB_SRC_DIV12 = 3'h0;
    localparam logic [2:0] CTB_SRC_DIV4 = 3'h1;
    localparam logic [2:0] CTB_SRC_T0OVF = 3'h2;
    localparam logic [2:0] CTB_SRC_ECI = 3'h3;
    localparam logic [2:0] CTB_SRC_SYS = 3'h4;
    localparam logic [2:0] CTB_SRC_OSC8 = 3'h5;
    localparam logic [3:0] CTB_DIV12_LAST = 4'hB;
    localparam logic [1:0] CTB_DIV4_LAST = 2'h3;
    localparam logic [2:0] CTB_OSC_LAST = 3'h7;
    localparam logic [15:0] CTB_CNT_MAX = 16'hFFFF;
    typedef enum logic [1:0] {
        CTB_WS_IDLE = 2'b01,
        CTB_WS_RESP = 2'b10
    } ctb_wst_t;
endpackage : ctb_pkg

module ctb_sync (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous pin and its edges
    input wire logic pin_in,
    output logic rise,
    output logic fall
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            rise <= s2_r & ~s3_r;
            fall <= ~s2_r & s3_r;
        end
    end
endmodule : ctb_sync

// File: src/ctb_timebase.sv
// Counter array timebase: 16-bit counter, tick select, overflow, AXI4-Lite.
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ctb_timebase
    import ctb_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Tick sources and processor state
    input wire logic timer0_ovf,
    input wire logic cpu_idle,
    input wire logic external_count_input,
    input wire logic ext_osc_in,
    // Results
    output logic irq,
    output logic [15:0] count_value
);
    // ***********************************************************************
    // State
    // ***********************************************************************
    typedef struct packed {
        ctb_wst_t wst;
        logic aw_got;
        logic w_got;
        logic [2:0] waddr;
        logic wmap;
        logic [7:0] wdata;
        logic wstb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0] div;
        logic [2:0] osc_div;
        logic eci_pend;
        logic [15:0] count;
        logic [7:0] snap;
        logic irq_en;
        logic [2:0] sel;
        logic idle_susp;
        logic wdog;
        logic flag;
        logic mask;
        logic irq;
    } ctb_state_t;
    ctb_state_t st_r;
    ctb_state_t st_nxt;
    logic eci_fall;
    logic osc_rise;
    logic div4_tick;
    logic div12_tick;
    logic hold;
    logic adv;
    logic wr_do;
    logic ar_fire;
    logic cnt_wr;
    logic [2:0] raddr;
    // The pins are asynchronous, so each passes two flops first.
    ctb_sync u_eci_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(external_count_input),
        .rise(),
        .fall(eci_fall)
    );
    ctb_sync u_osc_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(ext_osc_in),
        .rise(osc_rise),
        .fall()
    );
    // ***********************************************************************
    // Next state
    // ***********************************************************************
    always_comb begin
        st_nxt = st_r;
        raddr = s_axi_araddr[4:2];
        div12_tick = (st_r.div == CTB_DIV12_LAST);
        div4_tick = (st_r.div[1:0] == CTB_DIV4_LAST);
        hold = st_r.idle_susp & cpu_idle;
        wr_do = (st_r.wst == CTB_WS_IDLE) & st_r.aw_got & st_r.w_got;
        ar_fire = s_axi_arvalid & st_r.arready;
        cnt_wr = wr_do & st_r.wstb & ~st_r.wdog &
            ((st_r.waddr == CTB_IDX_CNT_LO) | (st_r.waddr == CTB_IDX_CNT_HI));
        // Prescaler shared by the divide-by-12 and divide-by-4 sources.
        st_nxt.div = div12_tick ? 4'h0 : st_r.div + 4'h1;
        // Edges faster than the divide-by-4 rate merge into one tick.
        if (eci_fall) begin
            st_nxt.eci_pend = 1'b1;
        end else if (div4_tick) begin
            st_nxt.eci_pend = 1'b0;
        end
        if (osc_rise) begin
            st_nxt.osc_div = st_r.osc_div + 3'h1;
        end
        case (st_r.sel)
            CTB_SRC_DIV12: adv = div12_tick;
            CTB_SRC_DIV4: adv = div4_tick;
            CTB_SRC_T0OVF: adv = timer0_ovf;
            CTB_SRC_ECI: adv = div4_tick & st_r.eci_pend;
            CTB_SRC_SYS: adv = 1'b1;
            CTB_SRC_OSC8: adv = osc_rise && st_r.osc_div == CTB_OSC_LAST;
            default: adv = 1'b0;
        endcase
        adv = adv & ~hold;
        // Reads are side-effect free for the counter itself.
        if (adv) begin
            st_nxt.count = st_r.count + 16'h0001;
        end
        if (s_axi_awvalid & st_r.awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.waddr = s_axi_awaddr[4:2];
            st_nxt.wmap = (s_axi_awaddr[31:5] == 27'h000_0000) &
                (s_axi_awaddr[4:2] <= CTB_IDX_MASK);
        end
        if (s_axi_wvalid & st_r.wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata[7:0];
            st_nxt.wstb = s_axi_wstrb[0];
        end
        if (wr_do) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = st_r.wmap ? CTB_RESP_OKAY : CTB_RESP_SLVERR;
            st_nxt.wst = CTB_WS_RESP;
            if (cnt_wr && st_r.waddr == CTB_IDX_CNT_LO) begin
                st_nxt.count[7:0] = st_r.wdata;
            end
            if (cnt_wr && st_r.waddr == CTB_IDX_CNT_HI) begin
                st_nxt.count[15:8] = st_r.wdata;
            end
            if (st_r.wmap && st_r.wstb && st_r.waddr == CTB_IDX_MODE) begin
                if (!st_r.wdog) begin
                    st_nxt.irq_en = st_r.wdata[CTB_MODE_IRQEN];
                    st_nxt.sel = st_r.wdata[CTB_MODE_SEL_LO +: 3];
                    st_nxt.idle_susp = st_r.wdata[CTB_MODE_IDLE];
                end
                // Only turning the watchdog off is honoured while it runs.
                st_nxt.wdog = st_r.wdog & st_r.wdata[CTB_MODE_WDOG];
            end
            if (st_r.wmap && st_r.wstb && st_r.waddr == CTB_IDX_STAT &&
                    st_r.wdata[0]) begin
                st_nxt.flag = 1'b0;
            end
            if (st_r.wmap && st_r.wstb && st_r.waddr == CTB_IDX_MASK) begin
                st_nxt.mask = st_r.wdata[0];
            end
        end else if (st_r.wst == CTB_WS_RESP && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
            st_nxt.wst = CTB_WS_IDLE;
        end
        // A wrap beats a clear in the same cycle.
        if (adv && st_r.count == CTB_CNT_MAX && !cnt_wr) begin
            st_nxt.flag = 1'b1;
        end
        st_nxt.awready = ~st_nxt.aw_got & (st_nxt.wst == CTB_WS_IDLE);
        st_nxt.wready = ~st_nxt.w_got & (st_nxt.wst == CTB_WS_IDLE);
        if (ar_fire) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = CTB_RESP_OKAY;
            st_nxt.rdata = 32'h0000_0000;
            if (s_axi_araddr[31:5] != 27'h000_0000) begin
                st_nxt.rresp = CTB_RESP_SLVERR;
            end else begin
                case (raddr)
                    CTB_IDX_CNT_LO: begin
                        st_nxt.rdata[7:0] = st_r.count[7:0];
                        st_nxt.snap = st_r.count[15:8];
                    end
                    CTB_IDX_CNT_HI: st_nxt.rdata[7:0] = st_r.snap;
                    CTB_IDX_MODE: begin
                        st_nxt.rdata[CTB_MODE_IRQEN] = st_r.irq_en;
                        st_nxt.rdata[CTB_MODE_SEL_LO +: 3] = st_r.sel;
                        st_nxt.rdata[CTB_MODE_IDLE] = st_r.idle_susp;
                        st_nxt.rdata[CTB_MODE_WDOG] = st_r.wdog;
                    end
                    CTB_IDX_STAT: st_nxt.rdata[0] = st_r.flag;
                    CTB_IDX_MASK: st_nxt.rdata[0] = st_r.mask;
                    default: st_nxt.rresp = CTB_RESP_SLVERR;
                endcase
            end
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        st_nxt.arready = ~st_nxt.rvalid;
        st_nxt.irq = st_nxt.flag & st_nxt.irq_en & st_nxt.mask;
    end
    // ***********************************************************************
    // Registers
    // ***********************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.wst <= CTB_WS_IDLE;
            st_r.awready <= 1'b1;
            st_r.wready <= 1'b1;
            st_r.arready <= 1'b1;
            st_r.sel <= CTB_SEL_RESET;
            st_r.wdog <= CTB_WDOG_RESET;
            st_r.mask <= CTB_MASK_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign irq = st_r.irq;
    assign count_value = st_r.count;
    // ***********************************************************************
    // Assertions
    // ***********************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0] chk_hi_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chk_hi_r <= 8'h00;
        end else if (ar_fire && raddr == CTB_IDX_CNT_LO &&
                s_axi_araddr[31:5] == 27'h000_0000) begin
            chk_hi_r <= st_r.count[15:8];
        end
    end
    sequence s_hi_read;
        ar_fire && raddr == CTB_IDX_CNT_HI &&
            s_axi_araddr[31:5] == 27'h000_0000;
    endsequence
    property p_snapshot;
        s_hi_read |=> s_axi_rdata[7:0] == chk_hi_r;
    endproperty
    a_snapshot: assert property (p_snapshot)
        else $error("high byte read did not return snapshot");
    property p_read_no_disturb;
        ar_fire && adv && !cnt_wr |=>
            count_value == $past(count_value) + 16'h0001;
    endproperty
    a_read_no_disturb: assert property (p_read_no_disturb)
        else $error("read disturbed the counter");
    property p_div12;
        adv && st_r.sel == CTB_SRC_DIV12 |-> st_r.div == CTB_DIV12_LAST;
    endproperty
    a_div12: assert property (p_div12)
        else $error("divide by 12 tick at wrong phase");
    property p_eci_rate;
        adv && st_r.sel == CTB_SRC_ECI |=> !adv[*3];
    endproperty
    a_eci_rate: assert property (p_eci_rate)
        else $error("external ticks closer than four clocks");
    property p_osc8;
        adv && st_r.sel == CTB_SRC_OSC8 |-> osc_rise && st_r.osc_div == 3'h7;
    endproperty
    a_osc8: assert property (p_osc8)
        else $error("oscillator tick not on eighth edge");
    property p_wrap;
        adv && count_value == CTB_CNT_MAX && !cnt_wr |=> st_r.flag &&
            count_value == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap did not set overflow flag");
    property p_irq;
        irq == (st_r.flag && st_r.irq_en && st_r.mask);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not follow flag and enable");
    property p_flag_sticky;
        st_r.flag && !(wr_do && st_r.waddr == CTB_IDX_STAT) |=> st_r.flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("overflow flag cleared without software");
    property p_idle_run;
        cpu_idle && !st_r.idle_susp && st_r.sel == CTB_SRC_SYS |-> adv;
    endproperty
    a_idle_run: assert property (p_idle_run)
        else $error("counter stopped in idle without suspend");
    property p_wdog_lock;
        st_r.wdog && wr_do && st_r.waddr == CTB_IDX_MODE |=>
            st_r.sel == $past(st_r.sel);
    endproperty
    a_wdog_lock: assert property (p_wdog_lock)
        else $error("mode changed while watchdog enabled");
    property p_reserved;
        st_r.sel[2:1] == 2'b11 |-> !adv;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("counter advanced on reserved source");
    property p_idle_hold;
        cpu_idle && st_r.idle_susp && !cnt_wr |=>
            count_value == $past(count_value);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("counter moved during suspended idle");
endmodule : ctb_timebase

// File: test/ctb_timebase_tb_top.sv
// Self-checking bench for the counter array timebase.
`timescale 1ns/100ps
module ctb_timebase_tb_top;
    import ctb_pkg::*;
    // ****************
    // Signals
    // ****************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0000_0000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [31:0] s_axi_araddr = 32'h0000_0000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic timer0_ovf = 1'b0;
    logic cpu_idle = 1'b0;
    logic external_count_input = 1'b1;
    logic ext_osc_in = 1'b0;
    logic irq;
    logic [15:0] count_value;
    int errors = 0;
    int tests_run = 0;
    logic [31:0] rd;
    logic [1:0] rsp;
    logic [15:0] c0;
    int exp_tab [8] = '{4, 12, 4, 4, 48, 1, 0, 0};
    localparam logic [31:0] A_LO = {27'h0, CTB_IDX_CNT_LO, 2'h0};
    localparam logic [31:0] A_HI = {27'h0, CTB_IDX_CNT_HI, 2'h0};
    localparam logic [31:0] A_MODE = {27'h0, CTB_IDX_MODE, 2'h0};
    localparam logic [31:0] A_STAT = {27'h0, CTB_IDX_STAT, 2'h0};
    localparam logic [31:0] A_MASK = {27'h0, CTB_IDX_MASK, 2'h0};

    always #5 aclk = ~aclk;

    ctb_timebase dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .timer0_ovf(timer0_ovf),
        .cpu_idle(cpu_idle), .external_count_input(external_count_input),
        .ext_osc_in(ext_osc_in), .irq(irq), .count_value(count_value)
    );

    // ****************
    // Bus tasks
    // ****************
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    // Address and data are dropped only at their own handshake edge.
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'h1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) begin
                s_axi_bready <= 1'b0;
                rsp = s_axi_bresp;
                return;
            end
        end
        errors++;
        summarize();
    endtask : wr

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1) begin
                s_axi_rready <= 1'b0;
                rd = s_axi_rdata;
                rsp = s_axi_rresp;
                check(rd, exp);
                return;
            end
        end
        errors++;
        summarize();
    endtask : rchk

    // Counts advance over n edges once the last setting has settled.
    task automatic delta(input int n, input logic [31:0] exp);
        cyc(2);
        c0 = count_value;
        cyc(n);
        check(32'(count_value - c0), exp);
    endtask : delta

    // ****************
    // Scenarios
    // ****************
    initial begin
        cyc(4);
        aresetn <= 1'b1;
        rchk(A_MODE, 32'h0000_0020);
        rchk(A_STAT, 32'h0000_0000);
        rchk(A_MASK, 32'h0000_0001);
        rchk(32'h0000_0014, 32'h0000_0000);
        check({30'h0, rsp}, {30'h0, CTB_RESP_SLVERR});
        wr(A_HI, 32'h0000_00AA);
        wr(A_MODE, 32'h0000_0028);
        rchk(A_MODE, 32'h0000_0020);
        check({24'h0, count_value[15:8]}, 32'h0000_0000);
        wr(A_MODE, 32'h0000_0000);
        rchk(A_MODE, 32'h0000_0000);
        // Each source gets the same 48-edge window with pulses and oscillator
        // activity, plus external edges for sources 3, 6 and 7; only the selected one may move the count.
        for (int s = 0; s < 8; s++) begin
            wr(A_MODE, {28'h0, s[2:0], 1'b0});
            @(posedge aclk);
            c0 = count_value;
            for (int k = 0; k < 48; k++) begin
                timer0_ovf <= (k < 32) && (k % 8 == 0);
                external_count_input <=
                    !((k < 32) && k[2] && (s == 3 || s > 5));
                ext_osc_in <= (k < 32) && k[1];
                @(posedge aclk);
            end
            check(32'(count_value - c0), exp_tab[s]);
        end
        wr(A_MODE, 32'h0000_0008);
        cpu_idle <= 1'b1;
        delta(20, 32'h0000_0014);
        wr(A_MODE, 32'h0000_0018);
        delta(20, 32'h0000_0000);
        cpu_idle <= 1'b0;
        delta(20, 32'h0000_0014);
        wr(A_MODE, 32'h0000_000C);
        wr(A_LO, 32'h0000_00FC);
        wr(A_HI, 32'h0000_00FF);
        delta(10, 32'h0000_0000);
        check({16'h0, count_value}, 32'h0000_FFFC);
        rchk(A_LO, 32'h0000_00FC);
        wr(A_MODE, 32'h0000_0008);
        cyc(10);
        rchk(A_HI, 32'h0000_00FF);
        check({24'h0, count_value[15:8]}, 32'h0000_0000);
        rchk(A_STAT, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0000);
        wr(A_MODE, 32'h0000_0009);
        cyc(3);
        check({31'h0, irq}, 32'h0000_0001);
        wr(A_MASK, 32'h0000_0000);
        cyc(3);
        check({31'h0, irq}, 32'h0000_0000);
        wr(A_MASK, 32'h0000_0001);
        cyc(100);
        check({31'h0, irq}, 32'h0000_0001);
        rchk(A_STAT, 32'h0000_0001);
        wr(A_STAT, 32'h0000_0001);
        cyc(3);
        rchk(A_STAT, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
        summarize();
    end
endmodule : ctb_timebase_tb_top
